// ==== hw/ppb_defs.svh ====
// Constants for the parallel byte port: codes, status bit positions, reset values
`ifndef PPB_DEFS_SVH
`define PPB_DEFS_SVH
`define PPB_MODE_ADDR_SLAVE 2'h1
`define PPB_MODE_MASTER_TWO 2'h2
`define PPB_MODE_MASTER_ONE 2'h3
`define PPB_MUX_NONE 2'h0
`define PPB_MUX_PART 2'h1
`define PPB_MUX_FULL 2'h2
`define PPB_STEP_INC 2'h1
`define PPB_STEP_DEC 2'h2
`define PPB_CSF_NONE 2'h0
`define PPB_CSF_TWO 2'h2
`define PPB_SLAVE_LAST_ADDR 2'h3
`define PPB_ST_IBF 15
`define PPB_ST_IBOV 14
`define PPB_ST_IN_BYTE_FULL_FLAG_LO 8
`define PPB_ST_OBE 7
`define PPB_ST_OUT_UNDERFLOW_FLAG 6
`define PPB_ST_OUT_BYTE_EMPTY_FLAG_LO 0
`define PPB_EMPTY_RST 4'hF
`define PPB_FULL_RST 4'h0
`define PPB_LOW_BYTE_MASK 14'h3FFF
`define PPB_MID_ADDR_MASK 6'h3F
`endif

// ==== hw/ppb_pkg.sv ====
// Types shared by the parallel byte port design
package ppb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALOW,
    ST_AHIGH,
    ST_BEGIN,
    ST_STROBE,
    ST_END
  } ppb_fsm_type;

  typedef struct packed {
    logic module_enable_bit;
    logic [1:0] port_mode_field;
    logic wide_data_bit;
    logic [1:0] addr_step_field;
    logic [1:0] addr_mux_field;
    logic [1:0] select_function_field;
    logic byte_enable_pin_on;
    logic write_pin_on;
    logic read_pin_on;
    logic [15:0] address_pin_enable_reg;
    logic [1:0] select_polarity_bits;
    logic read_polarity;
    logic write_polarity;
    logic byte_enable_polarity;
    logic latch_polarity;
    logic irq_on_last_only;
    logic [1:0] begin_wait_count;
    logic [3:0] middle_wait_count;
    logic [1:0] end_wait_count;
  } ppb_cfg_type;

  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
    logic [15:0] addr_out;
    logic [15:0] addr_oe;
    logic rd_out;
    logic rd_oe;
    logic wr_out;
    logic wr_oe;
    logic be_out;
    logic be_oe;
  } ppb_pins_type;

  typedef struct packed {
    ppb_fsm_type fsm;
    logic busy;
    logic byte1;
    logic is_wr;
    logic [3:0] cnt;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] addr;
    logic [3:0][7:0] out_buf;
    logic [3:0][7:0] in_buf;
    logic [3:0] empty;
    logic [3:0] full;
    logic all_out_empty_flag;
    logic all_in_full_flag;
    logic under;
    logic over;
    logic rd_act_q;
    logic wr_act_q;
    logic en_q;
    logic event_q;
    logic done_q;
    ppb_pins_type pins;
  } ppb_state_type;
endpackage

// ==== hw/ppb_sync.sv ====
// Two-stage synchroniser for host strobes
`timescale 1ns/100ps
module ppb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [1:0][WIDTH-1:0] st_q;
  logic [1:0][WIDTH-1:0] st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d[0] = async_in;
    st_d[1] = st_q[0];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q[1];
endmodule // ppb_sync

// ==== hw/ppb_port.sv ====
// Parallel byte port: addressable slave buffers and bus master engine
`timescale 1ns/100ps
`include "ppb_defs.svh"
module ppb_port (
  input wire logic clock,
  input wire logic reset,
  input wire ppb_pkg::ppb_cfg_type cfg,
  input wire logic [7:0] port_data_bus_in,
  input wire logic [1:0] slave_address_inputs,
  input wire logic chip_select_one_in,
  input wire logic read_strobe_in,
  input wire logic write_strobe_in,
  input wire logic sw_out_write,
  input wire logic sw_in_read,
  input wire logic [1:0] sw_index,
  input wire logic [7:0] sw_out_data,
  input wire logic sw_clear_underflow,
  input wire logic sw_clear_overflow,
  input wire logic sw_addr_write,
  input wire logic [15:0] sw_addr_data,
  input wire logic master_start,
  input wire logic master_write,
  input wire logic [15:0] master_write_data,
  output ppb_pkg::ppb_pins_type port_pins,
  output logic [15:0] port_status_reg,
  output logic [31:0] in_buffer_bytes,
  output logic [15:0] port_address_reg,
  output logic master_busy,
  output logic [15:0] master_read_data,
  output logic port_event
);
  ppb_pkg::ppb_state_type q;
  ppb_pkg::ppb_state_type d;
  logic [2:0] sync_out;
  logic slave_on;
  logic master_on;
  logic rd_act;
  logic wr_act;
  logic rd_evt;
  logic wr_end;
  logic go_data;
  logic fin;
  logic acc;
  logic dph;
  logic stb;
  logic [1:0] eb;
  logic [1:0] ee;
  logic [15:0] step_mask;
  logic [7:0] sel_out;

  // Host strobes are asynchronous; metastability kept out of the flag logic
  ppb_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({write_strobe_in, read_strobe_in, chip_select_one_in}),
    .sync_out(sync_out)
  );

  // Mode decode
  assign slave_on = cfg.module_enable_bit && cfg.port_mode_field == `PPB_MODE_ADDR_SLAVE;
  assign master_on = cfg.module_enable_bit && cfg.port_mode_field[1];

  // Qualified host strobes, polarity applied after synchronising
  assign rd_act = slave_on && (sync_out[0] ~^ cfg.select_polarity_bits[0])
    && (sync_out[1] ~^ cfg.read_polarity);
  assign wr_act = slave_on && (sync_out[0] ~^ cfg.select_polarity_bits[0])
    && (sync_out[2] ~^ cfg.write_polarity);
  assign rd_evt = rd_act && !q.rd_act_q;
  // Write is taken at its trailing edge, when the host data is settled
  assign wr_end = slave_on && !wr_act && q.wr_act_q;
  assign sel_out = q.out_buf[slave_address_inputs];

  // Begin and end waits only count when the strobe itself is stretched
  assign eb = (cfg.middle_wait_count == 4'h0) ? 2'h0 : cfg.begin_wait_count;
  assign ee = (cfg.middle_wait_count == 4'h0) ? 2'h0 : cfg.end_wait_count;

  // Bits that take part in stepping; select pins are held out
  assign step_mask = {cfg.select_function_field == `PPB_CSF_NONE,
    cfg.select_function_field != `PPB_CSF_TWO, `PPB_LOW_BYTE_MASK};

  function automatic logic level_of(input logic act, input logic pol);
    level_of = act ~^ pol;
  endfunction

  // Next state of the whole block
  always_comb begin
    d = q;
    go_data = 1'b0;
    fin = 1'b0;
    d.event_q = 1'b0;
    d.done_q = 1'b0;
    // Enabling the module restarts buffer bookkeeping, data is kept
    if (cfg.module_enable_bit && !q.en_q) begin
      d.empty = `PPB_EMPTY_RST;
      d.full = `PPB_FULL_RST;
      d.under = 1'b0;
      d.over = 1'b0;
    end
    d.en_q = cfg.module_enable_bit;
    d.rd_act_q = rd_act;
    d.wr_act_q = wr_act;

    // Software side first, so a host event in the same cycle wins
    if (sw_out_write) begin
      d.out_buf[sw_index] = sw_out_data;
      d.empty[sw_index] = 1'b0;
    end
    if (sw_in_read) begin
      d.full[sw_index] = 1'b0;
    end
    if (sw_clear_underflow) begin
      d.under = 1'b0;
    end
    if (sw_clear_overflow) begin
      d.over = 1'b0;
    end

    // Host read of an output byte
    if (rd_evt) begin
      d.empty[slave_address_inputs] = 1'b1;
      if (q.empty[slave_address_inputs]) begin
        d.under = 1'b1;
      end
    end
    // Host write into an input byte
    if (wr_end) begin
      if (q.full[slave_address_inputs]) begin
        d.over = 1'b1;
      end else begin
        d.in_buf[slave_address_inputs] = port_data_bus_in;
        d.full[slave_address_inputs] = 1'b1;
      end
    end
    if (rd_evt || wr_end) begin
      d.event_q = !cfg.irq_on_last_only || slave_address_inputs == `PPB_SLAVE_LAST_ADDR;
    end

    // Software writes reach the address register only while no access runs
    if (sw_addr_write && q.fsm == ppb_pkg::ST_IDLE) begin
      d.addr = sw_addr_data;
    end

    // Master access sequencer
    if (!master_on) begin
      d.fsm = ppb_pkg::ST_IDLE;
    end else begin
      case (q.fsm)
        ppb_pkg::ST_IDLE: begin
          if (master_start) begin
            d.is_wr = master_write;
            d.wdata = master_write_data;
            d.byte1 = 1'b0;
            if (cfg.addr_mux_field == `PPB_MUX_PART || cfg.addr_mux_field == `PPB_MUX_FULL) begin
              d.fsm = ppb_pkg::ST_ALOW;
              d.cnt = {2'h0, eb};
            end else begin
              go_data = 1'b1;
            end
          end
        end
        ppb_pkg::ST_ALOW: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else if (cfg.addr_mux_field == `PPB_MUX_FULL) begin
            d.fsm = ppb_pkg::ST_AHIGH;
            d.cnt = {2'h0, eb};
          end else begin
            go_data = 1'b1;
          end
        end
        ppb_pkg::ST_AHIGH: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else begin
            go_data = 1'b1;
          end
        end
        ppb_pkg::ST_BEGIN: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else begin
            d.fsm = ppb_pkg::ST_STROBE;
            d.cnt = cfg.middle_wait_count;
          end
        end
        ppb_pkg::ST_STROBE: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else begin
            // Read data sampled at the close of the strobe
            if (!q.is_wr && q.byte1) begin
              d.rdata[15:8] = port_data_bus_in;
            end else if (!q.is_wr) begin
              d.rdata[7:0] = port_data_bus_in;
            end
            if (ee != 2'h0) begin
              d.fsm = ppb_pkg::ST_END;
              d.cnt = {2'h0, ee} - 4'h1;
            end else begin
              fin = 1'b1;
            end
          end
        end
        ppb_pkg::ST_END: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else begin
            fin = 1'b1;
          end
        end
        default: begin
          d.fsm = ppb_pkg::ST_IDLE;
        end
      endcase
    end

    // Byte done: second byte of a word, or close the access and step
    if (fin) begin
      if (cfg.wide_data_bit && !q.byte1) begin
        d.byte1 = 1'b1;
        go_data = 1'b1;
      end else begin
        d.fsm = ppb_pkg::ST_IDLE;
        d.done_q = 1'b1;
        if (cfg.addr_step_field == `PPB_STEP_INC) begin
          d.addr = (q.addr & ~step_mask) | ((q.addr + 16'h1) & step_mask);
        end else if (cfg.addr_step_field == `PPB_STEP_DEC) begin
          d.addr = (q.addr & ~step_mask) | ((q.addr - 16'h1) & step_mask);
        end
      end
    end
    if (go_data) begin
      if (eb != 2'h0) begin
        d.fsm = ppb_pkg::ST_BEGIN;
        d.cnt = {2'h0, eb} - 4'h1;
      end else begin
        d.fsm = ppb_pkg::ST_STROBE;
        d.cnt = cfg.middle_wait_count;
      end
    end
    d.busy = d.fsm != ppb_pkg::ST_IDLE;
    d.all_out_empty_flag = &d.empty;
    d.all_in_full_flag = &d.full;

    // Pin levels follow the next state, so pins and state stay in step
    acc = d.fsm != ppb_pkg::ST_IDLE;
    stb = d.fsm == ppb_pkg::ST_STROBE;
    dph = stb || d.fsm == ppb_pkg::ST_BEGIN || d.fsm == ppb_pkg::ST_END;
    d.pins = '0;
    if (rd_act) begin
      d.pins.data_out = q.out_buf[slave_address_inputs];
      d.pins.data_oe = 1'b1;
    end
    if (master_on) begin
      if (d.fsm == ppb_pkg::ST_ALOW) begin
        d.pins.data_out = d.addr[7:0];
        d.pins.data_oe = 1'b1;
      end else if (d.fsm == ppb_pkg::ST_AHIGH) begin
        d.pins.data_out = d.addr[15:8] & {step_mask[15:14], `PPB_MID_ADDR_MASK};
        d.pins.data_oe = 1'b1;
      end else if (dph && d.is_wr) begin
        d.pins.data_out = d.byte1 ? d.wdata[15:8] : d.wdata[7:0];
        d.pins.data_oe = 1'b1;
      end
      for (int i = 0; i < 16; i++) begin
        d.pins.addr_out[i] = d.addr[i];
        d.pins.addr_oe[i] = cfg.address_pin_enable_reg[i];
      end
      // Multiplexed modes turn low address pins into latch strobes or I/O
      if (cfg.addr_mux_field == `PPB_MUX_PART) begin
        d.pins.addr_oe[7:1] = 7'h00;
        d.pins.addr_out[0] = level_of(d.fsm == ppb_pkg::ST_ALOW, cfg.latch_polarity);
      end else if (cfg.addr_mux_field == `PPB_MUX_FULL) begin
        d.pins.addr_oe[13:2] = 12'h000;
        d.pins.addr_out[0] = level_of(d.fsm == ppb_pkg::ST_ALOW, cfg.latch_polarity);
        d.pins.addr_out[1] = level_of(d.fsm == ppb_pkg::ST_AHIGH, cfg.latch_polarity);
      end
      // Select pins idle at their inactive level between accesses
      if (cfg.select_function_field != `PPB_CSF_NONE) begin
        d.pins.addr_out[15] = level_of(acc && d.addr[15], cfg.select_polarity_bits[1]);
      end
      if (cfg.select_function_field == `PPB_CSF_TWO) begin
        d.pins.addr_out[14] = level_of(acc && d.addr[14], cfg.select_polarity_bits[0]);
      end
      if (cfg.port_mode_field == `PPB_MODE_MASTER_TWO) begin
        d.pins.rd_out = level_of(stb && !d.is_wr, cfg.read_polarity);
        d.pins.wr_out = level_of(stb && d.is_wr, cfg.write_polarity);
      end else begin
        d.pins.rd_out = level_of(acc && !d.is_wr, cfg.read_polarity);
        d.pins.wr_out = level_of(stb, cfg.write_polarity);
      end
      d.pins.be_out = level_of(dph && d.byte1, cfg.byte_enable_polarity);
      d.pins.rd_oe = cfg.read_pin_on;
      d.pins.wr_oe = cfg.write_pin_on;
      d.pins.be_oe = cfg.byte_enable_pin_on;
    end
  end

  // State register; buffers start out empty
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.empty <= `PPB_EMPTY_RST;
      // All four bytes start empty, so the global flag starts set
      q.all_out_empty_flag <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Status word layout
  always_comb begin
    port_status_reg = 16'h0000;
    port_status_reg[`PPB_ST_IBF] = q.all_in_full_flag;
    port_status_reg[`PPB_ST_IBOV] = q.over;
    port_status_reg[`PPB_ST_IN_BYTE_FULL_FLAG_LO +: 4] = q.full;
    port_status_reg[`PPB_ST_OBE] = q.all_out_empty_flag;
    port_status_reg[`PPB_ST_OUT_UNDERFLOW_FLAG] = q.under;
    port_status_reg[`PPB_ST_OUT_BYTE_EMPTY_FLAG_LO +: 4] = q.empty;
  end

  assign port_pins = q.pins;
  assign in_buffer_bytes = q.in_buf;
  assign port_address_reg = q.addr;
  assign master_busy = q.busy;
  assign master_read_data = q.rdata;
  assign port_event = q.event_q;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  property p_rd_drive;
    rd_act |=> port_pins.data_oe && port_pins.data_out == $past(sel_out);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("slave read byte not driven");

  property p_empty_set;
    rd_evt |=> q.empty[$past(slave_address_inputs)] && (q.all_out_empty_flag == &q.empty);
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty flag not set");

  property p_underflow;
    rd_evt && q.empty[slave_address_inputs] |=> q.under && port_status_reg[6];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow missed");

  property p_capture;
    wr_end && !q.full[slave_address_inputs] |=> q.full[$past(slave_address_inputs)]
      && q.in_buf[$past(slave_address_inputs)] == $past(port_data_bus_in);
  endproperty
  a_capture: assert property (p_capture) else $error("input byte not captured");

  property p_discard;
    wr_end && q.full[slave_address_inputs] |=> q.over && $stable(q.in_buf);
  endproperty
  a_discard: assert property (p_discard) else $error("full byte overwritten");

  property p_event_last;
    wr_end && cfg.irq_on_last_only && slave_address_inputs != 2'h3 |=> !port_event;
  endproperty
  a_event_last: assert property (p_event_last) else $error("event on wrong address");

  property p_master_gate;
    !master_on |=> !master_busy;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("busy while not master");

  sequence s_full_start;
    q.fsm == ppb_pkg::ST_IDLE && master_on && master_start
      && cfg.addr_mux_field == 2'h2 && cfg.middle_wait_count == 4'h0;
  endsequence
  sequence s_two_addr;
    q.fsm == ppb_pkg::ST_ALOW ##1 q.fsm == ppb_pkg::ST_AHIGH ##1 q.fsm == ppb_pkg::ST_STROBE;
  endsequence
  property p_full_mux;
    s_full_start ##1 master_on |-> s_two_addr;
  endproperty
  a_full_mux: assert property (p_full_mux) else $error("full mux phases wrong");

  property p_step_inc;
    q.done_q && cfg.addr_step_field == 2'h1 && cfg.select_function_field == 2'h0
      |-> q.addr == $past(q.addr) + 16'h1;
  endproperty
  a_step_inc: assert property (p_step_inc) else $error("address not stepped");

  property p_cs_hold;
    q.done_q && cfg.select_function_field == 2'h2 |-> q.addr[15:14] == $past(q.addr[15:14]);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("select bits stepped");
endmodule // ppb_port

// ==== verif/ppb_host_model.sv ====
// Host model: drives the slave strobes and data pins of the port
`timescale 1ns/100ps
module ppb_host_model (
  input wire logic clock,
  input wire ppb_pkg::ppb_pins_type pins,
  output logic [7:0] data_bus,
  output logic [1:0] addr,
  output logic cs,
  output logic rd,
  output logic wr
);
  // Idle host: select and strobes inactive
  initial begin
    data_bus = 8'h00;
    addr = 2'h0;
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
  end

  // Strobe held three cycles so the synchroniser sees it
  task automatic host_write(input logic [1:0] idx, input logic [7:0] val);
    @(negedge clock);
    addr = idx;
    data_bus = val;
    cs = 1'b1;
    wr = 1'b1;
    repeat (3) @(negedge clock);
    cs = 1'b0;
    wr = 1'b0;
    // Data kept past the trailing edge, then released to a changed value
    repeat (4) @(negedge clock);
    data_bus = ~val;
  endtask

  // Bus sampled once the synchronised strobe has reached the pins
  task automatic host_read(input logic [1:0] idx, output logic [7:0] val, output logic oe);
    @(negedge clock);
    addr = idx;
    cs = 1'b1;
    rd = 1'b1;
    repeat (4) @(negedge clock);
    val = pins.data_out;
    oe = pins.data_oe;
    cs = 1'b0;
    rd = 1'b0;
    repeat (5) @(negedge clock);
  endtask
endmodule // ppb_host_model

// ==== verif/tb_top.sv ====
// Testbench for the parallel byte port: slave buffers and master cycles
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  ppb_pkg::ppb_cfg_type cfg;
  ppb_pkg::ppb_pins_type port_pins;
  logic [7:0] hdata, rdv, sw_out_data, first_data;
  logic first_latch, last_wr;
  logic [1:0] haddr, sw_index;
  logic hcs, hrd, hwr, roe, sw_out_write, sw_addr_write, master_start, master_busy, port_event;
  logic [15:0] port_status_reg, port_address_reg, master_read_data, sw_addr_data;
  logic [31:0] in_buffer_bytes;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int events = 0;
  int n;

  ppb_port u_ppb_port (.clock(clock), .reset(reset), .cfg(cfg), .port_data_bus_in(hdata),
    .slave_address_inputs(haddr), .chip_select_one_in(hcs), .read_strobe_in(hrd),
    .write_strobe_in(hwr), .sw_out_write(sw_out_write), .sw_in_read(1'b0),
    .sw_index(sw_index), .sw_out_data(sw_out_data), .sw_clear_underflow(1'b0),
    .sw_clear_overflow(1'b0), .sw_addr_write(sw_addr_write), .sw_addr_data(sw_addr_data),
    .master_start(master_start), .master_write(1'b1), .master_write_data(16'h005A),
    .port_pins(port_pins), .port_status_reg(port_status_reg),
    .in_buffer_bytes(in_buffer_bytes), .port_address_reg(port_address_reg),
    .master_busy(master_busy), .master_read_data(master_read_data), .port_event(port_event));
  ppb_host_model u_ppb_host_model (.clock(clock), .pins(port_pins), .data_bus(hdata),
    .addr(haddr), .cs(hcs), .rd(hrd), .wr(hwr));

  always #4 clock = ~clock;

  // Cycle ceiling and event tally
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (port_event === 1'b1) begin
      events <= events + 1;
    end
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Pulse start, count busy cycles; without end waits the last busy cycle is the strobe
  task automatic run_master();
    @(negedge clock);
    master_start = 1'b1;
    @(negedge clock);
    master_start = 1'b0;
    n = 0;
    while (master_busy === 1'b1 && n < 20) begin
      if (n == 0) begin
        first_data = port_pins.data_out;
        first_latch = port_pins.addr_out[0];
      end
      last_wr = port_pins.wr_out;
      n++;
      @(negedge clock);
    end
    if (n > 0) begin
      check("wr strobe", 32'h1, {31'h0, last_wr});
    end
  endtask

  task automatic test_write();
    u_ppb_host_model.host_write(2'h3, 8'hC3);
    check("in byte 3", 32'hC3, {24'h0, in_buffer_bytes[31:24]});
    check("full flag 3", 32'h1, {31'h0, port_status_reg[11]});
    u_ppb_host_model.host_write(2'h3, 8'h3C);
    check("kept byte 3", 32'hC3, {24'h0, in_buffer_bytes[31:24]});
    check("overflow", 32'h1, {31'h0, port_status_reg[14]});
    $display("test_write done");
  endtask

  task automatic test_read();
    @(negedge clock);
    sw_index = 2'h1;
    sw_out_data = 8'hA5;
    sw_out_write = 1'b1;
    @(negedge clock);
    sw_out_write = 1'b0;
    @(negedge clock);
    check("empties", 32'hD, {28'h0, port_status_reg[3:0]});
    u_ppb_host_model.host_read(2'h1, rdv, roe);
    check("read byte", 32'h1A5, {23'h0, roe, rdv});
    check("all empty", 32'h10F, {23'h0, port_status_reg[7], 4'h0, port_status_reg[3:0]});
    check("no underflow", 32'h0, {31'h0, port_status_reg[6]});
    u_ppb_host_model.host_read(2'h1, rdv, roe);
    check("underflow", 32'h1, {31'h0, port_status_reg[6]});
    $display("test_read done");
  endtask

  task automatic test_event_last();
    cfg.irq_on_last_only = 1'b1;
    events = 0;
    u_ppb_host_model.host_write(2'h0, 8'h11);
    check("no event at 00", 32'h0, events);
    u_ppb_host_model.host_read(2'h3, rdv, roe);
    check("event at 11", 32'h1, events);
    $display("test_event_last done");
  endtask

  task automatic test_master();
    cfg.port_mode_field = 2'h2;
    @(negedge clock);
    sw_addr_data = 16'h0010;
    sw_addr_write = 1'b1;
    @(negedge clock);
    sw_addr_write = 1'b0;
    run_master();
    check("demux length", 32'h1, n);
    check("demux data", 32'h05A, {23'h0, first_latch, first_data});
    check("step up", 32'h0011, {16'h0, port_address_reg});
    cfg.addr_mux_field = 2'h2;
    cfg.addr_step_field = 2'h2;
    run_master();
    check("full mux length", 32'h3, n);
    check("low addr phase", 32'h111, {23'h0, first_latch, first_data});
    check("step down", 32'h0010, {16'h0, port_address_reg});
    cfg.port_mode_field = 2'h1;
    run_master();
    check("slave start", 32'h0, n);
    $display("test_master done");
  endtask

  // Slave mode, select, read, write and latch active high; address, read and write pins enabled
  initial begin
    cfg = '0;
    cfg.module_enable_bit = 1'b1;
    cfg.port_mode_field = 2'h1;
    cfg.addr_step_field = 2'h1;
    cfg.write_pin_on = 1'b1;
    cfg.read_pin_on = 1'b1;
    cfg.address_pin_enable_reg = 16'hFFFF;
    cfg.select_polarity_bits = 2'h3;
    cfg.read_polarity = 1'b1;
    cfg.write_polarity = 1'b1;
    cfg.latch_polarity = 1'b1;
    sw_out_write = 1'b0;
    sw_addr_write = 1'b0;
    master_start = 1'b0;
    sw_index = 2'h0;
    sw_out_data = 8'h00;
    sw_addr_data = 16'h0000;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    check("status after reset", 32'h008F, {16'h0, port_status_reg});
    test_write();
    test_read();
    test_event_last();
    test_master();
    give_verdict();
  end
endmodule // tb_top
